/* File: bench/les_link_master.sv */
// fieldbus master station model feeding the supervisor's link side
`timescale 1ns/1ps
`default_nettype none

module les_link_master
  import les_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic rstn_in, // async reset, active low
  input wire logic break_in, // bench asks for a broken line
  input wire les_cmd_t cmd_in, // command the master wants to send
  output les_cmd_t link_cmd_out, // run/speed seen in link data
  output logic line_error_out // line error seen by the drive
);
  les_cmd_t last_q;
  logic brk_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_q <= '0;
      brk_q <= 1'b0;
    end else begin
      brk_q <= break_in;
      if (!break_in) begin
        last_q <= cmd_in;
      end
    end
  end

  // a dead line carries no valid data: show the inverse so stale values never pass
  assign link_cmd_out = brk_q ? ~last_q : last_q;
  assign line_error_out = brk_q;
endmodule // les_link_master

`default_nettype wire

/* File: bench/les_supervisor_tb.sv */
// self-checking testbench for the link error supervisor
`include "les_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module les_supervisor_tb
  import les_pkg::*;
;
  logic clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out, brk, circuit_fault_in, other_fault_in;
  logic stopped_in, coast_out, decel_out, accel_restart_out, alarm_output_out, fault_bit_out, link_exchange_en_out;
  logic line_error_in, nv_wr_out;
  logic [2:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, junk;
  logic [15:0] nv_mem, nv_data_out, cnt_exp;
  logic [7:0] display_code_out;
  les_cmd_t cmd_q, link_cmd_in, drive_cmd_out, saved;
  les_hist_t hist_out, last_hist;
  logic [1:0] m;
  logic [1:0] mtab [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  logic stab [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int err_total, checked, cycles;
  logic [31:0] v;

  les_supervisor #(.TENTH_CYCLES(10), .HOUR_TENTHS(5)) les_supervisor_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .line_error_in(line_error_in), .circuit_fault_in(circuit_fault_in),
    .other_fault_in(other_fault_in), .stopped_in(stopped_in), .link_cmd_in(link_cmd_in), .nv_count_in(nv_mem),
    .drive_cmd_out(drive_cmd_out), .coast_out(coast_out), .decel_out(decel_out),
    .accel_restart_out(accel_restart_out), .alarm_output_out(alarm_output_out), .fault_bit_out(fault_bit_out),
    .link_exchange_en_out(link_exchange_en_out), .display_code_out(display_code_out), .hist_out(hist_out),
    .nv_wr_out(nv_wr_out), .nv_data_out(nv_data_out));

  les_link_master les_link_master_i (.clk_in(clk_in), .rstn_in(rstn_in), .break_in(brk), .cmd_in(cmd_q),
    .link_cmd_out(link_cmd_in), .line_error_out(line_error_in));

  // ************************************************
  // clock, nonvolatile store, history capture, watchdog
  // ************************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (nv_wr_out === 1'b1) nv_mem <= nv_data_out;
    if (hist_out.wr === 1'b1) last_hist <= hist_out;
    if (cycles == 12000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ************************************************
  // tasks
  // ************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk1(input string nm, input logic seen, input logic exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask

  task automatic go();
    @(posedge clk_in);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  // request holds until waitrequest is seen low at a rising edge; only the watchdog ends a stall
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    bus(1'b1, a, d, junk);
  endtask

  task automatic rdchk(input string nm, input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask

  task automatic wait_pulse(input logic nv, input int lim);
    int n;
    n = 0;
    while ((nv ? nv_wr_out : accel_restart_out) !== 1'b1 && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    chk1("pulse seen", n < lim, 1'b1);
  endtask

  task automatic do_reset();
    go();
    rstn_in <= 1'b0;
    cyc(6);
    go();
    rstn_in <= 1'b1;
    cyc(3);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    {rstn_in, avs_read_in, avs_write_in, brk, circuit_fault_in, other_fault_in, stopped_in} = '0;
    avs_address_in = 3'h0;
    avs_writedata_in = 32'h0;
    err_total = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(68756));
    cmd_q = les_cmd_t'({1'b1, 16'($urandom)});
    nv_mem = 16'($urandom_range(0, 32'hff00));
    cnt_exp = nv_mem;
    do_reset();
    rdchk("count", `LES_OFF_COUNT, {16'h0, cnt_exp});
    wr(`LES_OFF_COUNT, 32'h5);
    rdchk("count", `LES_OFF_COUNT, {16'h0, cnt_exp});
    wr(`LES_OFF_COUNT, 32'h0);
    cnt_exp = 16'h0;
    rdchk("count", `LES_OFF_COUNT, 32'h0);
    rdchk("wait", `LES_OFF_WAIT, 32'h0);
    rdchk("mode", `LES_OFF_MODE, 32'h10);
    repeat (4) begin
      v = $urandom_range(0, 9998);
      wr(`LES_OFF_WAIT, v);
      rdchk("wait", `LES_OFF_WAIT, v);
    end
    wr(`LES_OFF_WAIT, 32'h270f);
    rdchk("wait", `LES_OFF_WAIT, v);
    wr(`LES_OFF_WAIT, 32'h270e);
    wr(`LES_OFF_WAIT, 32'hc000_0001);
    rdchk("wait", `LES_OFF_WAIT, 32'h270e);
    rdchk("unmapped", 3'h6, 32'h0);
    wr(`LES_OFF_WAIT, 32'h0);
    $display("test registers finished");

    for (int i = 0; i < 5; i++) begin
      m = mtab[i];
      wr(`LES_OFF_MODE, 32'h10 | {30'h0, m});
      cmd_q <= les_cmd_t'({1'b1, 16'($urandom)});
      cyc(3);
      saved = cmd_q;
      go();
      brk <= 1'b1;
      cnt_exp++;
      cyc(8);
      chk1("coast", coast_out, m == 2'h0);
      chk1("decel", decel_out, m == 2'h1 || m == 2'h2);
      chk1("alarm", alarm_output_out, m == 2'h0);
      chk1("fault bit", fault_bit_out, m == 2'h0);
      chk1("exchange", link_exchange_en_out, 1'b0);
      if (stab[i]) begin
        go();
        stopped_in <= 1'b1;
        cyc(4);
        chk1("alarm", alarm_output_out, m < 2'h2);
        chk("display", 32'(display_code_out), {24'h0, `LES_CODE_LINE});
        chk1("perm", last_hist.perm, m < 2'h2);
        chk("hist code", 32'(last_hist.code), {24'h0, `LES_CODE_LINE});
      end
      go();
      brk <= 1'b0;
      if (m == 2'h2) begin
        wait_pulse(1'b0, 20);
        chk("cmd", 32'(drive_cmd_out), 32'(saved));
      end
      cyc(3);
      chk1("alarm", alarm_output_out, m < 2'h2);
      chk("display", 32'(display_code_out), (m < 2'h2) ? {24'h0, `LES_CODE_LINE} : 32'h0);
      if (m < 2'h2) wr(`LES_OFF_CTRL, 32'h1);
      go();
      stopped_in <= 1'b0;
      cyc(2);
      chk1("alarm", alarm_output_out, 1'b0);
      chk1("exchange", link_exchange_en_out, 1'b1);
    end
    rdchk("count", `LES_OFF_COUNT, {16'h0, cnt_exp});
    $display("test stop modes finished");

    wr(`LES_OFF_MODE, 32'h13);
    go();
    circuit_fault_in <= 1'b1;
    cyc(6);
    chk1("coast", coast_out, 1'b1);
    chk("display", 32'(display_code_out), {24'h0, `LES_CODE_CIRCUIT});
    chk1("exchange", link_exchange_en_out, 1'b0);
    go();
    circuit_fault_in <= 1'b0;
    cyc(4);
    chk1("alarm", alarm_output_out, 1'b1);
    wr(`LES_OFF_CTRL, 32'h1);
    go();
    other_fault_in <= 1'b1;
    cyc(6);
    chk1("alarm", alarm_output_out, 1'b1);
    chk1("exchange", link_exchange_en_out, 1'b1);
    go();
    other_fault_in <= 1'b0;
    cyc(4);
    wr(`LES_OFF_CTRL, 32'h1);
    wr(`LES_OFF_MODE, 32'h0);
    go();
    brk <= 1'b1;
    cnt_exp++;
    cyc(8);
    chk1("alarm", alarm_output_out, 1'b0);
    chk1("coast", coast_out, 1'b0);
    chk1("exchange", link_exchange_en_out, 1'b0);
    go();
    brk <= 1'b0;
    cyc(4);
    wr(`LES_OFF_CTRL, 32'h1);
    wr(`LES_OFF_MODE, 32'h10);
    $display("test fault kinds finished");

    wr(`LES_OFF_WAIT, 32'h3);
    go();
    brk <= 1'b1;
    cnt_exp++;
    cyc(20);
    chk1("alarm", alarm_output_out, 1'b0);
    chk("display", 32'(display_code_out), 32'h0);
    cyc(30);
    chk1("alarm", alarm_output_out, 1'b1);
    go();
    brk <= 1'b0;
    cyc(4);
    wr(`LES_OFF_CTRL, 32'h1);
    go();
    brk <= 1'b1;
    cnt_exp++;
    cyc(15);
    go();
    brk <= 1'b0;
    cyc(40);
    chk1("alarm", alarm_output_out, 1'b0);
    chk("stored", 32'(nv_mem), 32'(cnt_exp));
    $display("test waiting time finished");

    wr(`LES_OFF_WAIT, 32'h64);
    go();
    brk <= 1'b1;
    cnt_exp++;
    wait_pulse(1'b1, 120);
    chk("nv data", 32'(nv_data_out), 32'(cnt_exp));
    go();
    brk <= 1'b0;
    cyc(3);
    go();
    brk <= 1'b1;
    cyc(4);
    go();
    brk <= 1'b0;
    do_reset();
    rdchk("count", `LES_OFF_COUNT, {16'h0, cnt_exp});
    rdchk("wait", `LES_OFF_WAIT, 32'h0);
    $display("test hourly store finished");
    tally_and_finish();
  end
endmodule // les_supervisor_tb

`default_nettype wire

/* File: core/les_defines.svh */
// constants for the link error supervisor: offsets, fields, reset values, timing
`ifndef LES_DEFINES_SVH
`define LES_DEFINES_SVH

// ************************************************
// register word offsets
// ************************************************
`define LES_OFF_WAIT 3'h0
`define LES_OFF_COUNT 3'h1
`define LES_OFF_MODE 3'h2
`define LES_OFF_CTRL 3'h3
`define LES_OFF_STATUS 3'h4
`define LES_OFF_LAST 3'h5

// ************************************************
// fields and reset values
// ************************************************
`define LES_MODE_STOP_LSB 0
`define LES_MODE_NET_BIT 4
`define LES_CTRL_RESET_BIT 0
`define LES_WAIT_RST 14'h0000
`define LES_WAIT_MAX 14'h270e
`define LES_STOP_RST 2'h0
`define LES_NET_RST 1'b1
`define LES_CODE_NONE 8'h00
`define LES_CODE_LINE 8'ha1
`define LES_CODE_CIRCUIT 8'hb1
`define LES_CODE_OTHER 8'hc0

// ************************************************
// timing
// ************************************************
`define LES_CLK_NS 10
`define LES_TENTH_NS 100000000
`define LES_TENTH_CYCLES (`LES_TENTH_NS / `LES_CLK_NS)
`define LES_HOUR_S 3600
`define LES_HOUR_TENTHS (`LES_HOUR_S * 10)

`endif

/* File: core/les_pkg.sv */
// types shared by the link error supervisor
package les_pkg;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_PENDING = 3'b001,
    ST_DECEL = 3'b010,
    ST_STOPPED = 3'b011,
    ST_CONT = 3'b100
  } les_state_t;

  typedef enum logic [1:0] {
    FK_NONE = 2'b00,
    FK_LINE = 2'b01,
    FK_CIRCUIT = 2'b10,
    FK_OTHER = 2'b11
  } les_kind_t;

  typedef struct packed {
    logic run;
    logic [15:0] speed;
  } les_cmd_t;

  typedef struct packed {
    logic wr;
    logic perm;
    logic [7:0] code;
  } les_hist_t;

endpackage

/* File: core/les_supervisor.sv */
// link error supervisor: wait timer, error counter, stop-mode actions, register slave
//
// How it works
// - a line error counts as recognised only after outlasting the waiting time.
// - link recovering before the waiting time ends returns to normal, no fault.
// - while an error waits, drive runs, normal display, no fault output.
// - writing zero to the counter register clears the count.
// - count copied to nonvolatile store at most hourly; reset restores stored copy.
// - recognised line error: mode 0 coast, 1 decel+alarm, 2 decel no alarm, 3 run.
// - circuit fault: modes 0,3 coast with alarm; modes 1,2 decel, alarm after stop.
// - on line clear modes 0,1 hold, mode 2 restarts, mode 3 runs; circuit latches.
// - a recognised line error shows fault code a1 on reaching ST_STOPPED; mode 3 and panel mode never stop and show none.
// - fault output drives both the alarm pin and the link fault bit.
// - asserting fault output writes a permanent history record.
// - without fault output the history record is temporary only.
// - after a non-latched error clears, display returns normal, last fault kept.
// - modes 1 and 2 stop using the ordinary deceleration settings.
// - restart accelerates with the ordinary acceleration settings.
// - mode 2 restart resumes the run and speed command saved before the error.
// - mode 2 line error clearing during deceleration restarts acceleration there.
// - link faults stop data exchange; act by stop mode in network mode, run in panel mode.
// - other drive faults trip in every mode while data exchange continues.
// - waiting time ranges 0 to 999.8 s in tenths, zero after reset.
`include "les_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module les_supervisor
  import les_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = `LES_TENTH_CYCLES,
  parameter int unsigned HOUR_TENTHS = `LES_HOUR_TENTHS
) (
  input wire logic clk_in, // 100 MHz system clock
  input wire logic rstn_in, // async reset, active low
  input wire logic [2:0] avs_address_in, // word index
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  input wire logic line_error_in, // link line error pin
  input wire logic circuit_fault_in, // internal link circuit fault pin
  input wire logic other_fault_in, // other drive fault pin
  input wire logic stopped_in, // drive reports standstill
  input wire les_cmd_t link_cmd_in, // run/speed from link data
  input wire logic [15:0] nv_count_in, // stored count from nonvolatile store
  output les_cmd_t drive_cmd_out, // command to the drive
  output logic coast_out, // free-run stop
  output logic decel_out, // stop on normal decel ramp
  output logic accel_restart_out, // restart pulse, normal accel ramp
  output logic alarm_output_out, // alarm pin
  output logic fault_bit_out, // fault bit in link data
  output logic link_exchange_en_out, // data exchange allowed
  output logic [7:0] display_code_out, // shown fault code, 0 = normal
  output les_hist_t hist_out, // fault history write
  output logic nv_wr_out, // store count pulse
  output logic [15:0] nv_data_out // count to store
);

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic line_prev;
    logic boot;
    logic ack;
    logic [31:0] rdata;
    logic [13:0] wait_t;
    logic [15:0] count;
    logic [15:0] nv_count;
    logic nv_wr;
    logic [1:0] stop_mode;
    logic net_mode;
    les_state_t st;
    les_kind_t kind;
    logic fault_out;
    logic coast;
    logic decel;
    logic accel;
    logic [31:0] wtick;
    logic [13:0] wtenths;
    logic [31:0] htick;
    logic [31:0] htenths;
    les_cmd_t saved;
    les_cmd_t [2:0] cmd_pipe;
    les_cmd_t cmd;
    les_hist_t hist;
    logic [7:0] display;
    logic [7:0] last_code;
  } les_regs_t;

  les_regs_t q;
  les_regs_t d;

  // ************************************************
  // helpers
  // ************************************************
  function automatic les_state_t act_state(les_kind_t k, logic [1:0] m, logic net);
    if (k == FK_OTHER) begin
      act_state = ST_STOPPED;
    end else if (!net) begin
      act_state = ST_CONT;
    end else if (k == FK_CIRCUIT) begin
      act_state = (m == 2'h0 || m == 2'h3) ? ST_STOPPED : ST_DECEL;
    end else begin
      case (m)
        2'h0: act_state = ST_STOPPED;
        2'h1: act_state = ST_DECEL;
        2'h2: act_state = ST_DECEL;
        default: act_state = ST_CONT;
      endcase
    end
  endfunction

  function automatic logic gives_alarm(les_kind_t k, logic [1:0] m);
    gives_alarm = !(k == FK_LINE && (m == 2'h2 || m == 2'h3));
  endfunction

  function automatic logic [7:0] kind_code(les_kind_t k);
    case (k)
      FK_LINE: kind_code = `LES_CODE_LINE;
      FK_CIRCUIT: kind_code = `LES_CODE_CIRCUIT;
      FK_OTHER: kind_code = `LES_CODE_OTHER;
      default: kind_code = `LES_CODE_NONE;
    endcase
  endfunction

  // ************************************************
  // combinational decode
  // ************************************************
  logic line_s, circ_s, other_s, line_rise, bus_go, wr_go, clear_wr, err_reset;
  logic recog, tenth_wrap, hour_wrap, restart;
  les_kind_t enter_kind;

  assign line_s = q.sync2[0];
  assign circ_s = q.sync2[1];
  assign other_s = q.sync2[2];
  assign line_rise = line_s && !q.line_prev;
  // one wait state: the answer is ready at the second edge of every request
  assign bus_go = (avs_read_in || avs_write_in) && q.ack;
  assign wr_go = bus_go && avs_write_in;
  assign clear_wr = wr_go && avs_address_in == `LES_OFF_COUNT && avs_writedata_in[15:0] == 16'h0000;
  assign err_reset = wr_go && avs_address_in == `LES_OFF_CTRL && avs_writedata_in[`LES_CTRL_RESET_BIT];
  assign tenth_wrap = q.wtick >= TENTH_CYCLES - 1;
  assign hour_wrap = q.htick >= TENTH_CYCLES - 1 && q.htenths >= HOUR_TENTHS - 1;
  assign recog = q.st == ST_PENDING && line_s && q.wtenths >= q.wait_t;
  // only a line fault in stop mode 2 may restart on its own
  assign restart = q.kind == FK_LINE && q.stop_mode == 2'h2 && !line_s && q.net_mode
    && (q.st == ST_DECEL || q.st == ST_STOPPED);

  always_comb begin
    enter_kind = FK_NONE;
    if (q.st == ST_NORMAL || q.st == ST_PENDING) begin
      if (circ_s) begin
        enter_kind = FK_CIRCUIT;
      end else if (recog) begin
        enter_kind = FK_LINE;
      end else if (other_s) begin
        enter_kind = FK_OTHER;
      end
    end
  end

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    d = q;
    d.sync1 = {other_fault_in, circuit_fault_in, line_error_in};
    d.sync2 = q.sync1;
    d.line_prev = line_s;
    d.accel = 1'b0;
    d.hist.wr = 1'b0;
    d.nv_wr = 1'b0;

    // register slave
    d.ack = (avs_read_in || avs_write_in) && !q.ack;
    if (avs_read_in && !q.ack) begin
      case (avs_address_in)
        `LES_OFF_WAIT: d.rdata = {18'h00000, q.wait_t};
        `LES_OFF_COUNT: d.rdata = {16'h0000, q.count};
        `LES_OFF_MODE: d.rdata = {27'h0000000, q.net_mode, 2'h0, q.stop_mode};
        `LES_OFF_STATUS: d.rdata = {16'h0000, q.display, 1'b0, q.st, q.kind, q.fault_out, line_s};
        `LES_OFF_LAST: d.rdata = {24'h000000, q.last_code};
        default: d.rdata = 32'h00000000;
      endcase
    end
    if (wr_go) begin
      case (avs_address_in)
        `LES_OFF_WAIT: begin
          if (avs_writedata_in[31:14] == 18'h00000 && avs_writedata_in[13:0] <= `LES_WAIT_MAX) begin
            d.wait_t = avs_writedata_in[13:0];
          end
        end
        `LES_OFF_MODE: begin
          d.stop_mode = avs_writedata_in[`LES_MODE_STOP_LSB +: 2];
          d.net_mode = avs_writedata_in[`LES_MODE_NET_BIT];
        end
        default: begin
        end
      endcase
    end

    // occurrence counter, an increment in the clearing cycle wins
    if (clear_wr) begin
      d.count = 16'h0000;
    end
    if (line_rise && q.count != 16'hffff) begin
      d.count = clear_wr ? 16'h0001 : q.count + 16'h0001;
    end

    // hourly copy, written only when the count moved
    d.htick = q.htick + 32'h1;
    if (q.htick >= TENTH_CYCLES - 1) begin
      d.htick = 32'h0;
      d.htenths = hour_wrap ? 32'h0 : q.htenths + 32'h1;
    end
    if (hour_wrap && d.count != q.nv_count) begin
      d.nv_wr = 1'b1;
      d.nv_count = d.count;
    end
    if (q.boot) begin
      d.boot = 1'b0;
      d.count = nv_count_in;
      d.nv_count = nv_count_in;
    end

    // wait timer, only runs while an error is pending
    if (q.st == ST_PENDING) begin
      d.wtick = tenth_wrap ? 32'h0 : q.wtick + 32'h1;
      if (tenth_wrap && q.wtenths != 14'h3fff) begin
        d.wtenths = q.wtenths + 14'h0001;
      end
    end else begin
      d.wtick = 32'h0;
      d.wtenths = 14'h0000;
    end

    // command path: follow the link while running
    case (q.st)
      ST_NORMAL, ST_PENDING, ST_CONT: d.cmd = link_cmd_in;
      default: d.cmd.run = 1'b0;
    endcase
    // link data spoils as the line breaks, two cycles before line_rise: keep the older word
    d.cmd_pipe = {q.cmd_pipe[1:0], link_cmd_in};
    if (line_rise && q.st == ST_NORMAL) begin
      d.saved = q.cmd_pipe[2];
    end

    case (q.st)
      ST_NORMAL: begin
        if (enter_kind == FK_NONE && line_rise) begin
          d.st = ST_PENDING;
        end
      end
      ST_PENDING: begin
        if (enter_kind == FK_NONE && !line_s) begin
          d.st = ST_NORMAL;
        end
      end
      ST_DECEL: begin
        if (restart) begin
          d.st = ST_NORMAL;
        end else if (stopped_in) begin
          d.st = ST_STOPPED;
          d.decel = 1'b0;
          d.fault_out = gives_alarm(q.kind, q.stop_mode);
          d.display = kind_code(q.kind);
          d.last_code = kind_code(q.kind);
          d.hist = '{wr: 1'b1, perm: gives_alarm(q.kind, q.stop_mode), code: kind_code(q.kind)};
        end
      end
      ST_STOPPED: begin
        if (restart) begin
          d.st = ST_NORMAL;
        end else if (err_reset && !line_s && !circ_s && !other_s) begin
          d.st = ST_NORMAL;
        end
      end
      ST_CONT: begin
        if (q.kind == FK_LINE && !line_s) begin
          d.st = ST_NORMAL;
        end else if (err_reset && !circ_s && !line_s) begin
          d.st = ST_NORMAL;
        end
      end
      default: d.st = ST_NORMAL;
    endcase

    if (enter_kind != FK_NONE) begin
      d.kind = enter_kind;
      d.st = act_state(enter_kind, q.stop_mode, q.net_mode);
      d.coast = d.st == ST_STOPPED;
      d.decel = d.st == ST_DECEL;
      if (d.st == ST_STOPPED) begin
        d.fault_out = gives_alarm(enter_kind, q.stop_mode);
        d.display = kind_code(enter_kind);
        d.last_code = kind_code(enter_kind);
        d.hist = '{wr: 1'b1, perm: gives_alarm(enter_kind, q.stop_mode), code: kind_code(enter_kind)};
      end
    end

    // leaving a fault: display back to normal, last code stays readable
    if (q.st != ST_NORMAL && q.st != ST_PENDING && d.st == ST_NORMAL) begin
      d.kind = FK_NONE;
      d.fault_out = 1'b0;
      d.coast = 1'b0;
      d.decel = 1'b0;
      d.display = `LES_CODE_NONE;
      if (restart) begin
        d.accel = 1'b1;
        d.cmd = q.saved;
      end
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      q.boot <= 1'b1;
      q.wait_t <= `LES_WAIT_RST;
      q.stop_mode <= `LES_STOP_RST;
      q.net_mode <= `LES_NET_RST;
      q.st <= ST_NORMAL;
      q.kind <= FK_NONE;
    end else begin
      q <= d;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign avs_readdata_out = q.rdata;
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !q.ack;
  assign drive_cmd_out = q.cmd;
  assign coast_out = q.coast;
  assign decel_out = q.decel;
  assign accel_restart_out = q.accel;
  assign alarm_output_out = q.fault_out;
  assign fault_bit_out = q.fault_out;
  // data exchange halts only for the two link fault kinds
  assign link_exchange_en_out = !((q.kind == FK_LINE || q.kind == FK_CIRCUIT)
    && q.st != ST_NORMAL && q.st != ST_PENDING);
  assign display_code_out = q.display;
  assign hist_out = q.hist;
  assign nv_wr_out = q.nv_wr;
  assign nv_data_out = q.nv_count;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_decel_stop;
    q.st == ST_DECEL && stopped_in && !restart;
  endsequence

  a_wait_not_early: assert property (
    q.st == ST_PENDING && q.wtenths < q.wait_t && !circ_s && !other_s |=> q.st != ST_STOPPED && q.st != ST_DECEL
  ) else $error("line error acted on before the waiting time");

  a_recover_quiet: assert property (
    q.st == ST_PENDING && !line_s && !circ_s && !other_s |=> q.st == ST_NORMAL && !q.fault_out
  ) else $error("recovered link did not return to normal");

  a_pending_runs: assert property (
    q.st == ST_PENDING |-> !q.fault_out && !q.coast && !q.decel && q.display == `LES_CODE_NONE
  ) else $error("drive disturbed while error pending");

  a_count_step: assert property (
    line_rise && !clear_wr && !q.boot && q.count != 16'hffff |=> q.count == $past(q.count) + 16'h0001
  ) else $error("occurrence count did not step");

  a_count_clear: assert property (
    clear_wr && !line_rise && !q.boot |=> q.count == 16'h0000
  ) else $error("count not cleared by zero write");

  a_nv_hourly: assert property (
    q.nv_wr |-> $past(hour_wrap) && q.nv_count == q.count
  ) else $error("count stored outside the hourly slot");

  a_mode0_coast: assert property (
    recog && !circ_s && q.stop_mode == 2'h0 && q.net_mode |=> q.st == ST_STOPPED && q.coast && q.fault_out
  ) else $error("mode 0 did not coast with alarm");

  a_decel_alarm: assert property (
    s_decel_stop |=> q.st == ST_STOPPED && q.fault_out == gives_alarm($past(q.kind), $past(q.stop_mode)) && q.hist.wr
  ) else $error("stop after deceleration mishandled");

  a_mode2_restart: assert property (
    restart |=> q.st == ST_NORMAL && q.accel && q.cmd == $past(q.saved) ##1 !q.accel
  ) else $error("mode 2 restart missing");

  a_alarm_record: assert property (
    $rose(q.fault_out) |-> q.hist.wr && q.hist.perm && alarm_output_out && fault_bit_out
  ) else $error("fault output without permanent record");

  a_line_code: assert property (
    q.kind == FK_LINE && q.display != `LES_CODE_NONE |-> q.display == `LES_CODE_LINE
  ) else $error("wrong code for line error");

endmodule // les_supervisor

`default_nettype wire
